// [verilog/cph_config_handshake.sv]
/*
  pin handshake between a configuration host and the configuration manager.
  assumes host pins are synchronous to SYS_CLK; load progress comes from
  the configuration manager as plain level and pulse ports.
*/
// Summary of operation
// - rising edge of request line starts configuration or reconfiguration
// - acknowledge follows request level, except after an error
// - request low during a cycle abandons it; wait for new cycle
// - configuration error drives acknowledge low for 0.5 to 10 ms
// - no error pulse for partial reconfiguration or test-port failures
// - error pulse may be asynchronous to error detection
// - no automatic restart after error; host must toggle request
// - acknowledge is actively driven both levels, never open-drain
// - both done indications low before and during configuration
// - load complete flag asserts after all configuration data received
// - user mode indication asserts on entry to user mode
// - seventeen multi-purpose pins, functions set by bitstream settings
// - pins 0, 8, 16 weakly low at power-on, others weakly high
module cph_config_handshake
  import cph_pkg::*;
#(
  parameter int PIN_COUNT = MP_PIN_COUNT,
  parameter int ERR_CYC = ERR_PULSE_MIN_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CONFIG_REQUEST_N,
  output logic CONFIG_ACK_ERROR_N,
  output logic CONFIG_ACK_ERROR_OE_N,
  input wire logic DATA_DONE,
  input wire logic DATA_ERROR,
  input wire logic ERROR_IS_PARTIAL,
  input wire logic ERROR_IS_TEST_PORT,
  input wire logic INIT_DONE_IN,
  input wire logic LOAD_BUSY_IN,
  input wire logic PIN_SETTINGS_VALID,
  input wire logic [MP_SEL_W-1:0] LOAD_FLAG_SEL,
  input wire logic [MP_SEL_W-1:0] USER_FLAG_SEL,
  output logic STREAM_ACCEPT_READY,
  output logic START_CLEAR,
  output logic START_LOAD,
  output logic LOAD_COMPLETE_FLAG,
  output logic USER_MODE_FLAG,
  output logic USER_RESET_RELEASE,
  output logic [PIN_COUNT-1:0] MP_PIN_OUT,
  output logic [PIN_COUNT-1:0] MP_PIN_OE_N,
  output logic [PIN_COUNT-1:0] MP_PULL_UP,
  output logic [PIN_COUNT-1:0] MP_PULL_DOWN,
  output logic [2:0] STATE_OUT
);
  // ==========================================================
  // checks
  initial begin
    if (PIN_COUNT != MP_PIN_COUNT) begin
      $error("pin count must match the pull map");
    end
  end

  // ==========================================================
  // request edges
  cph_state_type state_ff;
  cph_state_type nxt_state;
  logic req_ff;
  logic req_rise;
  logic req_fall;
  logic err_start;
  logic err_busy;
  logic ack_ff;
  logic load_flag_ff;
  logic user_flag_ff;
  logic assigned_ff;
  logic [MP_SEL_W-1:0] load_sel_ff;
  logic [MP_SEL_W-1:0] user_sel_ff;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      req_ff <= 1'b1;
    end else begin
      req_ff <= CONFIG_REQUEST_N;
    end
  end
  assign req_rise = CONFIG_REQUEST_N && !req_ff;
  assign req_fall = !CONFIG_REQUEST_N && req_ff;

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_POR: begin
        if (!CONFIG_REQUEST_N) begin
          nxt_state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        nxt_state = ST_WAIT_RELEASE;
      end
      ST_WAIT_RELEASE: begin
        if (req_rise) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (req_fall) begin
          nxt_state = ST_CLEAR;
        end else if (err_start) begin
          nxt_state = ST_ERROR;
        end else if (DATA_DONE) begin
          nxt_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (req_fall) begin
          nxt_state = ST_CLEAR;
        end else if (INIT_DONE_IN) begin
          nxt_state = ST_USER;
        end
      end
      ST_USER: begin
        if (req_fall) begin
          nxt_state = ST_CLEAR;
        end
      end
      ST_ERROR: begin
        if (!err_busy) begin
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: begin
        // stays until the host toggles the request line
        if (!CONFIG_REQUEST_N) begin
          nxt_state = ST_CLEAR;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // error pulse
  // partial or test-port failures never reach the status line
  assign err_start = (state_ff == ST_LOAD) && DATA_ERROR && !ERROR_IS_PARTIAL
                     && !ERROR_IS_TEST_PORT;

  cph_err_pulse #(
    .PULSE_CYC(ERR_CYC)
  ) u_err_pulse (
    .clk(SYS_CLK),
    .rst(RST),
    .start(err_start),
    .busy(err_busy)
  );

  // ==========================================================
  // acknowledge / status
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ack_ff <= 1'b1;
    end else if (state_ff == ST_ERROR || err_start) begin
      ack_ff <= 1'b0;
    end else if (state_ff == ST_HALT) begin
      ack_ff <= CONFIG_REQUEST_N;
    end else begin
      ack_ff <= CONFIG_REQUEST_N;
    end
  end
  assign CONFIG_ACK_ERROR_N = ack_ff;
  assign CONFIG_ACK_ERROR_OE_N = 1'b0;

  // ==========================================================
  // done indications
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      load_flag_ff <= 1'b0;
      user_flag_ff <= 1'b0;
    end else begin
      load_flag_ff <= (state_ff == ST_INIT) || (state_ff == ST_USER);
      user_flag_ff <= (state_ff == ST_USER);
    end
  end
  assign LOAD_COMPLETE_FLAG = load_flag_ff;
  assign USER_MODE_FLAG = user_flag_ff;
  assign USER_RESET_RELEASE = user_flag_ff && !LOAD_BUSY_IN;

  // ==========================================================
  // control strobes to the configuration manager
  assign START_CLEAR = (state_ff == ST_CLEAR);
  assign START_LOAD = (state_ff == ST_WAIT_RELEASE) && req_rise;
  assign STREAM_ACCEPT_READY = (state_ff == ST_LOAD) && ack_ff && !LOAD_BUSY_IN;
  assign STATE_OUT = state_ff;

  // ==========================================================
  // multi-purpose pin settings
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      assigned_ff <= 1'b0;
      load_sel_ff <= MP_SEL_NONE;
      user_sel_ff <= MP_SEL_NONE;
    end else if (PIN_SETTINGS_VALID) begin
      assigned_ff <= 1'b1;
      load_sel_ff <= LOAD_FLAG_SEL;
      user_sel_ff <= USER_FLAG_SEL;
    end
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    cph_mp_pin #(
      .INDEX(i)
    ) u_pin (
      .clk(SYS_CLK),
      .rst(RST),
      .assigned(assigned_ff),
      .load_sel(load_sel_ff),
      .user_sel(user_sel_ff),
      .load_done(load_flag_ff),
      .user_done(user_flag_ff),
      .pin_out(MP_PIN_OUT[i]),
      .pin_oe_n(MP_PIN_OE_N[i]),
      .pull_up(MP_PULL_UP[i]),
      .pull_down(MP_PULL_DOWN[i])
    );
  end
endmodule : cph_config_handshake

// [shared/cph_pkg.sv]
/*
  constants for the configuration pin handshake block.
  assumes a 100 MHz system clock and synchronous active-high reset.
*/
package cph_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERR_PULSE_MIN_US = 500;
  localparam int ERR_PULSE_MAX_US = 10000;
  localparam int ERR_PULSE_MIN_CYC = (ERR_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_PULSE_MAX_CYC = (ERR_PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
  // ==========================================================
  // multi-purpose pins
  localparam int MP_PIN_COUNT = 17;
  localparam int MP_SEL_W = 5;
  localparam logic [MP_PIN_COUNT-1:0] MP_PULL_UP_RST = 17'h0fefe;
  localparam logic [MP_SEL_W-1:0] MP_SEL_NONE = 5'h1f;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    ST_POR, ST_CLEAR, ST_WAIT_RELEASE, ST_LOAD, ST_INIT, ST_USER, ST_ERROR, ST_HALT
  } cph_state_type;
endpackage : cph_pkg

// [verilog/cph_err_pulse.sv]
/*
  error pulse timer: holds busy for a fixed number of cycles after start.
  assumes start is a one-cycle pulse on the system clock.
*/
module cph_err_pulse
  import cph_pkg::*;
#(
  parameter int PULSE_CYC = ERR_PULSE_MIN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  // ==========================================================
  // checks
  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > ERR_PULSE_MAX_CYC) begin
      $error("pulse length out of range");
    end
  end
  logic [19:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 20'h00000;
    end else if (start) begin
      cnt_ff <= 20'(PULSE_CYC);
    end else if (cnt_ff != 20'h00000) begin
      cnt_ff <= cnt_ff - 20'h00001;
    end
  end
  assign busy = (cnt_ff != 20'h00000);
endmodule : cph_err_pulse

// [verilog/cph_mp_pin.sv]
/*
  one multi-purpose pin: weak power-on pull, or a driven done indication.
  assumes sel is stable after the pin settings are loaded.
*/
module cph_mp_pin
  import cph_pkg::*;
#(
  parameter int INDEX = 0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic assigned,
  input wire logic [MP_SEL_W-1:0] load_sel,
  input wire logic [MP_SEL_W-1:0] user_sel,
  input wire logic load_done,
  input wire logic user_done,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pull_up,
  output logic pull_down
);
  logic out_ff;
  logic oe_n_ff;
  logic is_load;
  logic is_user;
  assign is_load = assigned && (load_sel == MP_SEL_W'(INDEX));
  assign is_user = assigned && (user_sel == MP_SEL_W'(INDEX));
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      out_ff <= (is_load && load_done) || (is_user && user_done);
      oe_n_ff <= !(is_load || is_user);
    end
  end
  assign pin_out = out_ff;
  assign pin_oe_n = oe_n_ff;
  // weak pulls until the pin settings are loaded
  assign pull_up = !assigned && MP_PULL_UP_RST[INDEX];
  assign pull_down = !assigned && !MP_PULL_UP_RST[INDEX];
endmodule : cph_mp_pin

// [sim/cph_config_handshake_asserts.sv]
/* checker on the ports of the configuration pin handshake.
   assumes it is bound to cph_config_handshake. */
module cph_config_handshake_asserts
  import cph_pkg::*;
#(
  parameter int PIN_COUNT = MP_PIN_COUNT,
  parameter int ERR_CYC = ERR_PULSE_MIN_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CONFIG_REQUEST_N,
  input wire logic CONFIG_ACK_ERROR_N,
  input wire logic CONFIG_ACK_ERROR_OE_N,
  input wire logic DATA_DONE,
  input wire logic DATA_ERROR,
  input wire logic ERROR_IS_PARTIAL,
  input wire logic ERROR_IS_TEST_PORT,
  input wire logic LOAD_COMPLETE_FLAG,
  input wire logic USER_MODE_FLAG,
  input wire logic [PIN_COUNT-1:0] MP_PULL_UP,
  input wire logic [PIN_COUNT-1:0] MP_PULL_DOWN,
  input wire logic [2:0] STATE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // low run counter
  logic [31:0] low_cnt_ff;
  always_ff @(posedge SYS_CLK) begin
    if (RST) low_cnt_ff <= 32'h0;
    else if (!CONFIG_ACK_ERROR_N && CONFIG_REQUEST_N) low_cnt_ff <= low_cnt_ff + 32'h1;
    else low_cnt_ff <= 32'h0;
  end
  // ==========
  // properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence err_hit;
    DATA_ERROR && STATE_OUT == 3'h3 && CONFIG_REQUEST_N;
  endsequence
  sequence done_hit;
    DATA_DONE && !DATA_ERROR && STATE_OUT == 3'h3 && CONFIG_REQUEST_N;
  endsequence
  drive_both_a: assert property (!CONFIG_ACK_ERROR_OE_N) else $error("ack undriven");
  rise_load_a: assert property ($rose(CONFIG_REQUEST_N) && STATE_OUT == 3'h2
    |=> STATE_OUT == 3'h3) else $error("no load on rise");
  ack_low_a: assert property (STATE_OUT inside {3'h1, 3'h2} |-> !CONFIG_ACK_ERROR_N)
    else $error("ack not low");
  ack_high_a: assert property (STATE_OUT inside {[3'h3:3'h5]} |-> CONFIG_ACK_ERROR_N)
    else $error("ack not high");
  abort_clear_a: assert property ($fell(CONFIG_REQUEST_N) && STATE_OUT inside {[3'h3:3'h5]}
    |=> STATE_OUT == 3'h1) else $error("no abort");
  err_low_a: assert property (err_hit ##0 !ERROR_IS_PARTIAL && !ERROR_IS_TEST_PORT
    |=> !CONFIG_ACK_ERROR_N && STATE_OUT == 3'h6) else $error("no error pulse");
  err_len_a: assert property ($rose(CONFIG_ACK_ERROR_N) && CONFIG_REQUEST_N
    |-> low_cnt_ff == 32'h1 || low_cnt_ff inside {[ERR_CYC:ERR_CYC+2]})
    else $error("bad low length");
  err_skip_a: assert property (err_hit ##0 (ERROR_IS_PARTIAL || ERROR_IS_TEST_PORT)
    && !DATA_DONE |=> CONFIG_ACK_ERROR_N) else $error("qualified error pulsed");
  halt_stay_a: assert property (STATE_OUT == 3'h7 && CONFIG_REQUEST_N
    |=> STATE_OUT == 3'h7) else $error("restart after error");
  flags_low_a: assert property (STATE_OUT inside {[3'h0:3'h3]}
    && $past(STATE_OUT) inside {[3'h0:3'h3]} |-> !LOAD_COMPLETE_FLAG && !USER_MODE_FLAG)
    else $error("flag early");
  load_flag_a: assert property (done_hit |=> STATE_OUT == 3'h4 ##1 LOAD_COMPLETE_FLAG)
    else $error("no load flag");
  user_flag_a: assert property (STATE_OUT == 3'h5 |=> USER_MODE_FLAG)
    else $error("no user flag");
  pull_map_a: assert property ($fell(RST) |-> MP_PULL_UP == MP_PULL_UP_RST
    && MP_PULL_DOWN == ~MP_PULL_UP_RST) else $error("bad pulls");
endmodule : cph_config_handshake_asserts

bind cph_config_handshake cph_config_handshake_asserts #(.PIN_COUNT(PIN_COUNT),
  .ERR_CYC(ERR_CYC)) i_asserts (.SYS_CLK, .RST, .CONFIG_REQUEST_N, .CONFIG_ACK_ERROR_N,
  .CONFIG_ACK_ERROR_OE_N, .DATA_DONE, .DATA_ERROR, .ERROR_IS_PARTIAL, .ERROR_IS_TEST_PORT,
  .LOAD_COMPLETE_FLAG, .USER_MODE_FLAG, .MP_PULL_UP, .MP_PULL_DOWN, .STATE_OUT);

// [sim/cph_host_model.sv]
/* configuration host model driving the request line.
   assumes want_n comes from the bench; slow adds a cycle of lag. */
module cph_host_model (
  input wire logic clk,
  input wire logic ack_n,
  input wire logic want_n,
  input wire logic slow,
  output logic req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic match_ff = 1'b0;
  initial req_n = 1'b1;
  // ==========
  // moves only while request equals ack
  always @(posedge clk) begin
    match_ff <= (req_n === ack_n);
    if (req_n === ack_n && (match_ff || !slow) && want_n !== req_n) req_n <= want_n;
  end
endmodule : cph_host_model

// [sim/cph_config_handshake_test.sv]
/* self-checking bench for the configuration pin handshake.
   assumes the host model and the bound checker. */
module cph_config_handshake_test import cph_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERR_CYC = 20;
  logic clk = 1'b0, rst = 1'b1, want_n = 1'b1, slow = 1'b0, req_n, ack_n, ack_oe_n;
  logic done = 1'b0, err = 1'b0, e_part = 1'b0, e_test = 1'b0, init_done = 1'b0;
  logic busy = 1'b0, pin_valid = 1'b0, ready, st_clr, st_ld, lcf, umf, rel;
  logic [4:0] load_sel = 5'h1f, user_sel = 5'h1f;
  logic [16:0] p_out, p_oe_n, p_up, p_dn;
  logic [2:0] state;
  int failures = 0, check_count = 0;
  int load_starts = 0;
  always @(negedge clk) begin
    if (st_ld === 1'b1) load_starts++;
  end
  always #5 clk = ~clk;
  cph_host_model i_cph_host_model (.clk(clk), .ack_n(ack_n), .want_n(want_n), .slow(slow),
    .req_n(req_n));
  cph_config_handshake #(.ERR_CYC(ERR_CYC)) i_cph_config_handshake (.SYS_CLK(clk), .RST(rst),
    .CONFIG_REQUEST_N(req_n), .CONFIG_ACK_ERROR_N(ack_n), .CONFIG_ACK_ERROR_OE_N(ack_oe_n),
    .DATA_DONE(done), .DATA_ERROR(err), .ERROR_IS_PARTIAL(e_part), .ERROR_IS_TEST_PORT(e_test),
    .INIT_DONE_IN(init_done), .LOAD_BUSY_IN(busy), .PIN_SETTINGS_VALID(pin_valid),
    .LOAD_FLAG_SEL(load_sel), .USER_FLAG_SEL(user_sel), .STREAM_ACCEPT_READY(ready),
    .START_CLEAR(st_clr), .START_LOAD(st_ld), .LOAD_COMPLETE_FLAG(lcf), .USER_MODE_FLAG(umf),
    .USER_RESET_RELEASE(rel), .MP_PIN_OUT(p_out), .MP_PIN_OE_N(p_oe_n), .MP_PULL_UP(p_up),
    .MP_PULL_DOWN(p_dn), .STATE_OUT(state));
  // ==========
  // shared tasks
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic t_request(input logic lvl);
    int i;
    want_n = lvl;
    for (i = 0; i < 200 && ack_n !== lvl; i++) @(negedge clk);
    chk(17'(ack_n), 17'(lvl));
  endtask : t_request
  // ==========
  // scenarios
  task automatic t_power_on();
    chk(p_up, MP_PULL_UP_RST);
    chk(p_dn, ~MP_PULL_UP_RST);
    chk(17'({ack_oe_n, ack_n, lcf, umf}), 17'h4);
  endtask : t_power_on
  task automatic t_config();
    int n0;
    t_request(1'b0);
    chk(17'({st_clr, state}), 17'h9);
    n0 = load_starts;
    t_request(1'b1);
    chk(17'(load_starts - n0), 17'h1);
    chk(17'({ack_n, ready, state}), 17'h1b);
    pin_valid = 1'b1;
    load_sel = 5'h10;
    user_sel = 5'h00;
    busy = 1'b1;
    cyc(1);
    chk(17'(ready), 17'h0);
    pin_valid = 1'b0;
    busy = 1'b0;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(1);
    chk(17'({lcf, umf, state}), 17'h14);
    init_done = 1'b1;
    cyc(2);
    chk(17'({lcf, umf, rel, state}), 17'h3d);
    cyc(1);
    chk(p_out & ~p_oe_n, 17'h10001);
    chk(p_oe_n, 17'h0fffe);
    busy = 1'b1;
    #1;
    chk(17'(rel), 17'h0);
    cyc(1);
    busy = 1'b0;
  endtask : t_config
  task automatic t_abort();
    init_done = 1'b0;
    t_request(1'b0);
    cyc(1);
    chk(17'({lcf, umf, state}), 17'h2);
    t_request(1'b1);
    t_request(1'b0);
    chk(17'(state), 17'h1);
  endtask : t_abort
  task automatic t_error();
    int n;
    slow = 1'b1;
    t_request(1'b1);
    e_part = 1'b1;
    err = 1'b1;
    cyc(1);
    e_part = 1'b0;
    e_test = 1'b1;
    cyc(1);
    e_test = 1'b0;
    chk(17'(ack_n), 17'h1);
    cyc(1);
    err = 1'b0;
    for (n = 0; n < 100 && ack_n !== 1'b1; n++) @(negedge clk);
    chk(17'(n >= ERR_CYC && n <= ERR_CYC + 2), 17'h1);
    cyc(3);
    chk(17'({ack_n, ready, state}), 17'h17);
  endtask : t_error
  task automatic t_reset();
    init_done = 1'b0;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    t_power_on();
    chk(p_oe_n, 17'h1ffff);
    chk(17'(state), 17'h0);
  endtask : t_reset
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_power_on();
    t_config();
    t_abort();
    t_error();
    t_config();
    t_reset();
    t_config();
    tally_and_finish();
  end
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule : cph_config_handshake_test
